// file: fpcr_pkg.sv
// ****************************************************************************
// Shared constants and types of the front-end power control register bank.
// ****************************************************************************
package fpcr_pkg;

  // Bus and register widths.
  localparam int unsigned FPCR_ADDR_W = 10;
  localparam int unsigned FPCR_DATA_W = 32;
  localparam int unsigned FPCR_REG_W = 16;
  localparam int unsigned FPCR_NUM_DIES = 2;
  localparam int unsigned FPCR_NUM_PAIRS = 8;
  localparam int unsigned FPCR_NUM_CHAN = 16;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] FPCR_IDX_DIE_SELECT = 8'h00;
  localparam logic [7:0] FPCR_IDX_CHAIN = 8'hC5;
  localparam logic [7:0] FPCR_IDX_DOPPLER = 8'hC6;

  // Reset values and masks of the storable bits.
  localparam logic [15:0] FPCR_RESET_VALUE = 16'h0000;
  localparam logic [15:0] FPCR_DIE_SELECT_MASK = 16'h0001;
  localparam logic [15:0] FPCR_CHAIN_MASK = 16'hFEFF;
  localparam logic [15:0] FPCR_DOPPLER_MASK = 16'h7F7F;
  localparam logic [15:0] FPCR_ADC_RUN_ALL = 16'hFFFF;

  // Field positions of the chain power control register.
  localparam int unsigned CH_GLOBAL = 15;
  localparam int unsigned CH_QUICK = 14;
  localparam int unsigned CH_PREAMP = 13;
  localparam int unsigned CH_ATTGAIN = 12;
  localparam int unsigned CH_PROF_HI = 11;
  localparam int unsigned CH_PROF_LO = 10;
  localparam int unsigned CH_LOWNF = 9;
  localparam int unsigned CH_PAIR_LO = 0;

  // Field positions of the Doppler control register.
  localparam int unsigned DP_HPF_EN = 14;
  localparam int unsigned DP_HPF_RES_HI = 13;
  localparam int unsigned DP_HPF_RES_LO = 12;
  localparam int unsigned DP_CLK_HI = 11;
  localparam int unsigned DP_CLK_LO = 10;
  localparam int unsigned DP_AMP_OFF = 9;
  localparam int unsigned DP_PATH = 8;
  localparam int unsigned DP_BUF1X = 6;
  localparam int unsigned DP_BUF16X = 5;
  localparam int unsigned DP_GAIN_HI = 4;
  localparam int unsigned DP_GAIN_LO = 0;

  // Power profile codes.
  localparam logic [1:0] PROF_LOW_NOISE = 2'h0;
  localparam logic [1:0] PROF_LOW_POWER = 2'h1;
  localparam logic [1:0] PROF_MEDIUM = 2'h2;
  localparam logic [1:0] PROF_RESERVED = 2'h3;

  // Power controls delivered to one amplifier die.
  typedef struct packed {
    logic fullSleep;
    logic quickSleep;
    logic preampSleep;
    logic attGainSleep;
    logic [1:0] profile;
    logic lowNoiseFigure;
  } fpcr_die_ctl_t;

  // Doppler path controls.
  typedef struct packed {
    logic highpassEnable;
    logic [1:0] highpassResistor;
    logic [1:0] clockRatio;
    logic sumAmpOff;
    logic pathSelect;
    logic singleRateBufType;
    logic sixteenRateBufType;
    logic [4:0] sumGain;
  } fpcr_doppler_t;

  // Bus slave states.
  typedef enum logic [0:0] {BusIdle, BusAnswer} fpcr_bus_state_t;

  // True when a byte address selects the register with the given index.
  function automatic logic fpcr_hit(input logic [9:0] addr, input logic [7:0] idx);
    fpcr_hit = (addr[9:2] == idx);
  endfunction

  // Merges write data into a register under byte enables and the storable mask.
  function automatic logic [15:0] fpcr_merge(input logic [15:0] old,
                                             input logic [15:0] wdata,
                                             input logic [1:0] be,
                                             input logic [15:0] mask);
    logic [15:0] laneMask;
    laneMask = {{8{be[1]}}, {8{be[0]}}};
    fpcr_merge = ((old & ~laneMask) | (wdata & laneMask)) & mask;
  endfunction

endpackage

// file: fpcr_reg16.sv
`timescale 1ns/1ps
// ****************************************************************************
// One 16-bit software register with byte enables.
// ****************************************************************************
module fpcr_reg16
  import fpcr_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hFFFF
)
(
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // Write port.
  input wire logic writeEn,
  input wire logic [15:0] writeData,
  input wire logic [1:0] byteEn,
  // Stored value.
  output logic [15:0] value_r
);

  logic [15:0] value_nxt;

  // Next value merges the written lanes; unstorable bits stay zero.
  assign value_nxt = fpcr_merge(value_r, writeData, byteEn, MASK);

  // Storage, frozen while the clock enable is low.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      value_r <= FPCR_RESET_VALUE;
    else if (clkEn && writeEn)
      value_r <= value_nxt;
  end

endmodule // fpcr_reg16

// file: fpcr_die_decode.sv
`timescale 1ns/1ps
// ****************************************************************************
// Power control decode for one amplifier die.
// ****************************************************************************
module fpcr_die_decode
  import fpcr_pkg::*;
#(
  parameter int unsigned DIE = 1
)
(
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // Stored controls.
  input wire logic [15:0] chainReg,
  input wire logic dieSelect,
  // Controls for this die.
  output fpcr_die_ctl_t ctl_r
);

  logic applies;
  logic [1:0] profileCode;
  logic [1:0] profileEff;
  fpcr_die_ctl_t ctl_nxt;

  // Die 1 always follows the register; die 2 only while the die-select flag is 0.
  assign applies = (DIE == 1) || !dieSelect;
  assign profileCode = chainReg[CH_PROF_HI:CH_PROF_LO];
  // The reserved code falls back to the low-noise profile.
  assign profileEff = (profileCode == PROF_RESERVED) ? PROF_LOW_NOISE : profileCode;

  // Sleep decode; global sleep masks quick sleep.
  assign ctl_nxt.fullSleep = applies && chainReg[CH_GLOBAL];
  assign ctl_nxt.quickSleep = applies && chainReg[CH_QUICK] && !chainReg[CH_GLOBAL];
  assign ctl_nxt.preampSleep = applies && chainReg[CH_PREAMP];
  assign ctl_nxt.attGainSleep = applies && chainReg[CH_ATTGAIN];
  assign ctl_nxt.profile = applies ? profileEff : PROF_LOW_NOISE;
  // Low noise figure acts only in the low-noise profile.
  assign ctl_nxt.lowNoiseFigure = applies && chainReg[CH_LOWNF]
                                  && (profileCode == PROF_LOW_NOISE);

  // Output register.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ctl_r <= '0;
    else if (clkEn)
      ctl_r <= ctl_nxt;
  end

endmodule // fpcr_die_decode

// file: fpcr_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Global sleep fully powers down chosen dies.
// - Global sleep overrides quick sleep.
// - Sleep bits never stop the converter.
// - Quick sleep partially powers down chosen dies.
// - Preamp sleep powers down preamplifier only.
// - Attenuator sleep powers down attenuator and gain.
// - Die-select flag limits settings to die 1.
// - Pair bits sleep pairs, even only when selected.
// - Pair sleep leaves converter channel running.
// - Doppler register holds its documented fields.
// - Path select; Doppler by itself leaves attenuator powered.
module fpcr_top
  import fpcr_pkg::*;
(
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // Avalon-MM slave.
  input wire logic [FPCR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [FPCR_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [FPCR_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Amplifier die controls, index 0 is die 1.
  output fpcr_die_ctl_t [FPCR_NUM_DIES-1:0] dieCtl_r,
  // Channel controls, bit k is channel k+1.
  output logic [FPCR_NUM_CHAN-1:0] chanSleep_r,
  output logic [FPCR_NUM_CHAN-1:0] adcChanRun_r,
  // Doppler path controls.
  output fpcr_doppler_t doppler_r
);

  // ****************************************************************************
  // Bus slave
  // ****************************************************************************

  fpcr_bus_state_t busState_r;
  fpcr_bus_state_t busState_nxt;
  logic waitReq_r;
  logic waitReq_nxt;
  logic [FPCR_DATA_W-1:0] readData_r;
  logic [FPCR_DATA_W-1:0] readData_nxt;
  logic request;
  logic writeTaken;
  logic hitDieSelect;
  logic hitChain;
  logic hitDoppler;
  logic [15:0] dieSelReg;
  logic [15:0] chainReg;
  logic [15:0] dopplerReg;
  logic [15:0] readWord;

  // Address decode and request qualification.
  assign request = avs_read || avs_write;
  assign hitDieSelect = fpcr_hit(avs_address, FPCR_IDX_DIE_SELECT);
  assign hitChain = fpcr_hit(avs_address, FPCR_IDX_CHAIN);
  assign hitDoppler = fpcr_hit(avs_address, FPCR_IDX_DOPPLER);
  // A write lands at the edge where waitrequest is seen low.
  assign writeTaken = (busState_r == BusAnswer) && avs_write;

  // Read selection; unmapped addresses read as zero.
  assign readWord = hitChain ? chainReg :
                    hitDoppler ? dopplerReg :
                    hitDieSelect ? dieSelReg : 16'h0000;
  assign readData_nxt = (busState_r == BusIdle) && avs_read ? {16'h0000, readWord} : readData_r;

  // Two-state answer: one wait cycle, then one cycle with waitrequest low.
  always_comb
  begin
    busState_nxt = busState_r;
    waitReq_nxt = 1'b1;
    case (busState_r)
      BusIdle:
      begin
        if (request)
        begin
          busState_nxt = BusAnswer;
          waitReq_nxt = 1'b0;
        end
      end
      BusAnswer:
      begin
        busState_nxt = BusIdle;
        waitReq_nxt = 1'b1;
      end
      default:
      begin
        busState_nxt = BusIdle;
        waitReq_nxt = 1'b1;
      end
    endcase
  end

  // Bus state registers.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busState_r <= BusIdle;
      waitReq_r <= 1'b1;
      readData_r <= '0;
    end
    else if (clkEn)
    begin
      busState_r <= busState_nxt;
      waitReq_r <= waitReq_nxt;
      readData_r <= readData_nxt;
    end
  end

  assign avs_waitrequest = waitReq_r;
  assign avs_readdata = readData_r;

  // ****************************************************************************
  // Register storage
  // ****************************************************************************

  // Die-select flag register.
  fpcr_reg16 #(.MASK(FPCR_DIE_SELECT_MASK)) dieSelStore (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .writeEn(writeTaken && hitDieSelect),
    .writeData(avs_writedata[15:0]),
    .byteEn(avs_byteenable[1:0]),
    .value_r(dieSelReg)
  );

  // Chain power control register; bit 8 is never stored.
  fpcr_reg16 #(.MASK(FPCR_CHAIN_MASK)) chainStore (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .writeEn(writeTaken && hitChain),
    .writeData(avs_writedata[15:0]),
    .byteEn(avs_byteenable[1:0]),
    .value_r(chainReg)
  );

  // Doppler control register; bits 15 and 7 are never stored.
  fpcr_reg16 #(.MASK(FPCR_DOPPLER_MASK)) dopplerStore (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .writeEn(writeTaken && hitDoppler),
    .writeData(avs_writedata[15:0]),
    .byteEn(avs_byteenable[1:0]),
    .value_r(dopplerReg)
  );

  // ****************************************************************************
  // Die and channel power decode
  // ****************************************************************************

  // One decoder per amplifier die.
  generate
    for (genvar d = 0; d < FPCR_NUM_DIES; d++)
    begin : gDie
      fpcr_die_decode #(.DIE(d + 1)) decode (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .chainReg(chainReg),
        .dieSelect(dieSelReg[0]),
        .ctl_r(dieCtl_r[d])
      );
    end
  endgenerate

  logic [FPCR_NUM_CHAN-1:0] chanSleep_nxt;

  // Pair p covers channels 2p+1 and 2p+2; the odd one is spared when die 1 alone is chosen.
  generate
    for (genvar p = 0; p < FPCR_NUM_PAIRS; p++)
    begin : gPair
      assign chanSleep_nxt[2*p] = chainReg[CH_PAIR_LO+p] && !dieSelReg[0];
      assign chanSleep_nxt[2*p+1] = chainReg[CH_PAIR_LO+p];
    end
  endgenerate

  // Channel and converter outputs; the converter enables ignore every sleep bit.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chanSleep_r <= '0;
      adcChanRun_r <= FPCR_ADC_RUN_ALL;
    end
    else if (clkEn)
    begin
      chanSleep_r <= chanSleep_nxt;
      adcChanRun_r <= FPCR_ADC_RUN_ALL;
    end
  end

  // ****************************************************************************
  // Doppler field decode
  // ****************************************************************************

  fpcr_doppler_t doppler_nxt;

  // Field extraction from the stored Doppler register.
  assign doppler_nxt.highpassEnable = dopplerReg[DP_HPF_EN];
  assign doppler_nxt.highpassResistor = dopplerReg[DP_HPF_RES_HI:DP_HPF_RES_LO];
  assign doppler_nxt.clockRatio = dopplerReg[DP_CLK_HI:DP_CLK_LO];
  assign doppler_nxt.sumAmpOff = dopplerReg[DP_AMP_OFF];
  assign doppler_nxt.pathSelect = dopplerReg[DP_PATH];
  assign doppler_nxt.singleRateBufType = dopplerReg[DP_BUF1X];
  assign doppler_nxt.sixteenRateBufType = dopplerReg[DP_BUF16X];
  assign doppler_nxt.sumGain = dopplerReg[DP_GAIN_HI:DP_GAIN_LO];

  // Doppler output register.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      doppler_r <= '0;
    else if (clkEn)
      doppler_r <= doppler_nxt;
  end

  // ****************************************************************************
  // Checks
  // ****************************************************************************

  // Global sleep masks quick sleep on die 1.
  quickMasked_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    dieCtl_r[0].fullSleep |-> !dieCtl_r[0].quickSleep)
    else $error("Quick sleep active together with global sleep.");

  // Die 1 full sleep follows the global bit one cycle later.
  fullSleep_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn |=> dieCtl_r[0].fullSleep == $past(chainReg[CH_GLOBAL]))
    else $error("Die 1 full sleep does not follow the global bit.");

  // With die 1 alone chosen, die 2 gets no sleep and the default profile.
  dieTwoFree_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && dieSelReg[0] |=> dieCtl_r[1] == '0)
    else $error("Die 2 affected while die 1 alone is selected.");

  // Quick sleep without global sleep reaches both dies when not restricted.
  quickBoth_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && chainReg[CH_QUICK] && !chainReg[CH_GLOBAL] && !dieSelReg[0]
    |=> dieCtl_r[0].quickSleep && dieCtl_r[1].quickSleep)
    else $error("Quick sleep missing on a die.");

  // Preamp sleep alone leaves the attenuator and gain stage powered.
  preampOnly_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && chainReg[CH_PREAMP] && !chainReg[CH_ATTGAIN]
    |=> dieCtl_r[0].preampSleep && !dieCtl_r[0].attGainSleep)
    else $error("Preamp sleep disturbs the attenuator.");

  // Doppler mode does not by itself power the attenuator down.
  dopplerAtt_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && dopplerReg[DP_PATH] && !chainReg[CH_ATTGAIN]
    |=> doppler_r.pathSelect && !dieCtl_r[0].attGainSleep)
    else $error("Attenuator asleep in Doppler mode.");

  // Reserved profile and low noise figure outside low-noise profile are refused.
  profileSafe_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    dieCtl_r[0].profile != PROF_RESERVED
    && (!dieCtl_r[0].lowNoiseFigure || dieCtl_r[0].profile == PROF_LOW_NOISE))
    else $error("Illegal profile combination on die 1.");

  // A restricted pair sleeps only its even channel.
  pairEven_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && chainReg[CH_PAIR_LO] && dieSelReg[0] |=> chanSleep_r[1:0] == 2'h2)
    else $error("Restricted pair sleep wrong on channels 1 and 2.");

  // Converter channels keep running whatever is asleep.
  adcRuns_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    adcChanRun_r == FPCR_ADC_RUN_ALL)
    else $error("Converter channel stopped.");

  // A full write to the Doppler register is stored under its mask.
  writeBack_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && writeTaken && hitDoppler && avs_byteenable[1:0] == 2'h3
    |=> dopplerReg == ($past(avs_writedata[15:0]) & FPCR_DOPPLER_MASK))
    else $error("Doppler register lost a write.");

  // A request seen while idle is answered at the next edge.
  answer_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clkEn && request && avs_waitrequest |=> !avs_waitrequest)
    else $error("Request not answered in one cycle.");

endmodule // fpcr_top

// file: fpcr_top_tb.sv
`timescale 1ns/1ps
// ****************************************************************************
// Self-checking bench of the front-end power control register bank.
// ****************************************************************************
module fpcr_top_tb;
  import fpcr_pkg::*;

  // Clock, reset and bus signals driven by the bench.
  logic sys_clk;
  logic rstn;
  logic clkEn;
  logic [FPCR_ADDR_W-1:0] avsAddress;
  logic avsRead;
  logic avsWrite;
  logic [FPCR_DATA_W-1:0] avsWritedata;
  logic [3:0] avsByteenable;
  logic [FPCR_DATA_W-1:0] avsReaddata;
  logic avsWaitrequest;
  fpcr_die_ctl_t [FPCR_NUM_DIES-1:0] dieCtl;
  logic [FPCR_NUM_CHAN-1:0] chanSleep;
  logic [FPCR_NUM_CHAN-1:0] adcChanRun;
  fpcr_doppler_t doppler;
  int failCount;
  int nCompared;
  logic [31:0] rdData;

  // Byte addresses of the three registers and of an unmapped word.
  localparam logic [9:0] A_FLAG = 10'h000;
  localparam logic [9:0] A_CHAIN = 10'h314;
  localparam logic [9:0] A_DOP = 10'h318;
  localparam logic [9:0] A_NONE = 10'h31C;

  fpcr_top fpcr_top_i (
    .sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .dieCtl_r(dieCtl), .chanSleep_r(chanSleep), .adcChanRun_r(adcChanRun),
    .doppler_r(doppler)
  );

  // Free-running 20 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ****************************************************************************
  // Shared tasks and expectations.
  // ****************************************************************************

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Compared %0d values, %0d mismatches.", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compares a seen value with the expected one and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low.
  task automatic busXfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                         input logic [3:0] be);
    bit got;
    got = 1'b0;
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWritedata <= d;
    avsByteenable <= be;
    for (int i = 0; i < 20 && !got; i++)
    begin
      @(posedge sys_clk);
      if (avsWaitrequest === 1'b0)
        got = 1'b1;
    end
    rdData = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (!got)
    begin
      failCount++;
      $display("[ERR] %0t ns: bus transfer never answered", $time);
      summarize();
    end
  endtask

  // Full-word write followed by a read-back compare.
  task automatic wrChk(input logic [9:0] a, input logic [15:0] d, input logic [15:0] m);
    busXfer(1'b1, a, {16'h0000, d}, 4'hF);
    busXfer(1'b0, a, 32'h0000_0000, 4'hF);
    check(rdData, {16'h0000, d & m});
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // Controls a die should receive when a chain setting reaches it.
  function automatic fpcr_die_ctl_t expDie(input logic [15:0] c);
    fpcr_die_ctl_t e;
    e.fullSleep = c[CH_GLOBAL];
    e.quickSleep = c[CH_QUICK] & ~c[CH_GLOBAL];
    e.preampSleep = c[CH_PREAMP];
    e.attGainSleep = c[CH_ATTGAIN];
    e.profile = (c[11:10] == PROF_RESERVED) ? PROF_LOW_NOISE : c[11:10];
    e.lowNoiseFigure = c[CH_LOWNF] & (c[11:10] == PROF_LOW_NOISE);
    return e;
  endfunction

  // Channel sleep pattern; with the flag set only even channels sleep.
  function automatic logic [15:0] expChan(input logic [7:0] p, input logic f);
    logic [15:0] r;
    for (int k = 0; k < 8; k++)
    begin
      r[2*k+1] = p[k];
      r[2*k] = p[k] & ~f;
    end
    return r;
  endfunction

  // ****************************************************************************
  // Scenarios.
  // ****************************************************************************

  // Reset values of registers and outputs.
  task automatic testReset();
    busXfer(1'b0, A_CHAIN, 32'h0, 4'hF);
    check(rdData, 32'h0000_0000);
    busXfer(1'b0, A_DOP, 32'h0, 4'hF);
    check(rdData, 32'h0000_0000);
    check(32'(dieCtl), 32'h0);
    check(32'(doppler), 32'h0);
    check(32'(chanSleep), 32'h0);
    check(32'(adcChanRun), 32'(FPCR_ADC_RUN_ALL));
    $display("testReset done");
  endtask

  // Every chain setting with the flag clear reaches both dies.
  task automatic testBothDies();
    logic [15:0] v [11];
    v = '{16'hC000, 16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0200, 16'h0600,
          16'h0400, 16'h0800, 16'h0C00, 16'hFCA5};
    foreach (v[i])
    begin
      wrChk(A_CHAIN, v[i], FPCR_CHAIN_MASK);
      check(32'(dieCtl[0]), 32'(expDie(v[i])));
      check(32'(dieCtl[1]), 32'(expDie(v[i])));
      check(32'(chanSleep), 32'(expChan(v[i][7:0], 1'b0)));
      check(32'(adcChanRun), 32'(FPCR_ADC_RUN_ALL));
    end
    $display("testBothDies done");
  endtask

  // With the flag set, settings act on die 1 and even channels only.
  task automatic testDieOne();
    logic [15:0] v [3];
    v = '{16'h2255, 16'hD6A5, 16'hB8FF};
    wrChk(A_CHAIN, 16'h0000, FPCR_CHAIN_MASK);
    wrChk(A_FLAG, 16'h0001, FPCR_DIE_SELECT_MASK);
    foreach (v[i])
    begin
      wrChk(A_CHAIN, v[i], FPCR_CHAIN_MASK);
      check(32'(dieCtl[0]), 32'(expDie(v[i])));
      check(32'(dieCtl[1]), 32'h0);
      check(32'(chanSleep), 32'(expChan(v[i][7:0], 1'b1)));
      check(32'(adcChanRun), 32'(FPCR_ADC_RUN_ALL));
    end
    wrChk(A_FLAG, 16'h0000, FPCR_DIE_SELECT_MASK);
    $display("testDieOne done");
  endtask

  // Doppler fields, and the attenuator left alone in continuous-wave mode.
  task automatic testDoppler();
    logic [15:0] v [4];
    v = '{16'h7F7F, 16'h4A35, 16'h8080, 16'h0100};
    wrChk(A_CHAIN, 16'h1000, FPCR_CHAIN_MASK);
    foreach (v[i])
    begin
      wrChk(A_DOP, v[i], FPCR_DOPPLER_MASK);
      check(32'(doppler), {18'h0, v[i][14:8], v[i][6:0]});
      check(32'(dieCtl[0].attGainSleep), 32'h1);
    end
    // Continuous-wave mode stays selected while the attenuator is woken.
    wrChk(A_CHAIN, 16'h0000, FPCR_CHAIN_MASK);
    check(32'(doppler.pathSelect), 32'h1);
    check(32'(dieCtl[0].attGainSleep), 32'h0);
    $display("testDoppler done");
  endtask

  // A low clock enable holds off the answer and freezes the channel sleep outputs.
  task automatic testFreeze();
    bit lowSeen;
    lowSeen = 1'b0;
    wrChk(A_CHAIN, 16'h0000, FPCR_CHAIN_MASK);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    fork
      busXfer(1'b1, A_CHAIN, 32'h0000_8001, 4'hF);
      begin
        repeat (5)
        begin
          @(posedge sys_clk);
          lowSeen = lowSeen | (avsWaitrequest !== 1'b1);
        end
        check(32'(lowSeen), 32'h0);
        check(32'(chanSleep), 32'h0);
        clkEn <= 1'b1;
      end
    join
    repeat (3) @(posedge sys_clk);
    #1;
    check(32'(dieCtl[0].fullSleep), 32'h1);
    check(32'(chanSleep), 32'(expChan(8'h01, 1'b0)));
    $display("testFreeze done");
  endtask

  // Byte lanes and an unmapped address.
  task automatic testBus();
    wrChk(A_CHAIN, 16'hFEFF, FPCR_CHAIN_MASK);
    busXfer(1'b1, A_CHAIN, 32'hFFFF_0000, 4'h1);
    busXfer(1'b0, A_CHAIN, 32'h0, 4'hF);
    check(rdData, 32'h0000_FE00);
    busXfer(1'b1, A_NONE, 32'h0000_FFFF, 4'hF);
    busXfer(1'b0, A_NONE, 32'h0, 4'hF);
    check(rdData, 32'h0000_0000);
    busXfer(1'b0, A_CHAIN, 32'h0, 4'hF);
    check(rdData, 32'h0000_FE00);
    $display("testBus done");
  endtask

  // Main sequence: reset for five cycles, then every scenario.
  initial
  begin
    failCount = 0;
    nCompared = 0;
    rstn = 1'b0;
    clkEn = 1'b1;
    avsAddress = '0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = '0;
    avsByteenable = 4'h0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    testReset();
    testBothDies();
    testDieOne();
    testDoppler();
    testFreeze();
    testBus();
    summarize();
  end

endmodule // fpcr_top_tb
